/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tcc_pkg::*;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic           gate, trig;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic [NCH-1:0] cap, cmp;
    logic [4:0]     obs;
    logic [5:0]     want;
    localparam int  PIN_HOLD = 2 * MC_CYCLES;
    int             err_count, num_checks;

    assign obs = {irq, cmp};
    always #(PCLK_NS / 2) pclk = ~pclk;

    tcc_timer i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_count_input(gate), .reload_trigger_input(trig), .capture_input(cap),
        .compare_output(cmp), .irq(irq)
    );
    tcc_pin_model #(.HOLD(PIN_HOLD)) i_pins (
        .pclk(pclk), .want(want), .gate_count_input(gate), .reload_trigger_input(trig),
        .capture_input(cap)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task tally_and_finish;
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task rng(input logic [7:0] a, input int lo, input int hi);
        apb(1'b0, a, 32'h0);
        chk(32'(rd >= lo && rd <= hi), 32'h1);
    endtask

    task wait_out(input int sel, input logic v);
        int n;
        n = 0;
        while (obs[sel] !== v && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // each level stands PIN_HOLD cycles, two machine cycles
    task set_gate(input logic v);
        @(posedge pclk);
        want[0] <= v;
        repeat (PIN_HOLD) @(posedge pclk);
    endtask

    task pulse(input int sel);
        @(posedge pclk);
        want[sel] <= 1'b0;
        repeat (PIN_HOLD) @(posedge pclk);
        want[sel] <= 1'b1;
        repeat (PIN_HOLD) @(posedge pclk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset;
        rdc(A_CTRL, 32'h0);
        rdc(A_COUNT, 32'h0);
        rdc(A_STAT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
    endtask

    task t_rate(input logic div12, input int exp);
        wr(A_CTRL, 32'h0);
        wr(A_COUNT, 32'h0);
        wr(A_CTRL, {29'h0, div12, 2'b01});
        repeat (120) @(posedge pclk);
        wr(A_CTRL, 32'h0);
        rng(A_COUNT, exp - 1, exp + 1);
    endtask

    task t_gated;
        set_gate(1'b0);
        wr(A_CTRL, 32'h0);
        wr(A_COUNT, 32'h0);
        wr(A_CTRL, 32'(TCC_GATED));
        repeat (60) @(posedge pclk);
        rdc(A_COUNT, 32'h0);
        set_gate(1'b1);
        repeat (60) @(posedge pclk);
        wr(A_CTRL, 32'h0);
        rng(A_COUNT, 9, 13);
    endtask

    task t_event;
        wr(A_CTRL, 32'h0);
        wr(A_COUNT, 32'h0);
        wr(A_CTRL, 32'(TCC_EVENT));
        repeat (5) pulse(0);
        repeat (24) @(posedge pclk);
        rdc(A_COUNT, 32'h5);
    endtask

    task t_reload;
        wr(A_CTRL, 32'h0);
        wr(A_STAT, 32'h3ff);
        wr(A_MASK, 32'h0);
        wr(A_COUNT, 32'hfffe);
        wr(A_RELOAD, 32'h1234);
        wr(A_CTRL, 32'h9);
        repeat (30) @(posedge pclk);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[ST_OVF]), 32'h1);
        chk(32'(irq), 32'h0);
        wr(A_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        wr(A_CTRL, 32'h0);
        rng(A_COUNT, 32'h1234, 32'h1240);
        wr(A_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        wr(A_MASK, 32'h0);
    endtask

    task t_trig;
        wr(A_CTRL, 32'h0);
        wr(A_STAT, 32'h3ff);
        wr(A_COUNT, 32'h0);
        wr(A_RELOAD, 32'h4321);
        wr(A_CTRL, 32'h38);
        pulse(1);
        rdc(A_COUNT, 32'h4321);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[ST_EXT]), 32'h1);
        wr(A_STAT, 32'h3ff);
        wr(A_COUNT, 32'h0);
        wr(A_CTRL, 32'h18);
        pulse(1);
        rdc(A_COUNT, 32'h4321);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[ST_EXT]), 32'h0);
    endtask

    task t_cmp0;
        wr(A_CTRL, 32'h0);
        wr(A_COUNT, 32'h0);
        wr(A_CC0, 32'h10);
        wr(A_CTRL, 32'h41);
        wr(A_PORT, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(cmp[0]), 32'h0);
        wait_out(0, 1'b1);
        wr(A_CTRL, 32'h0);
        rng(A_COUNT, 16, 17);
        wr(A_COUNT, 32'hfffe);
        wr(A_CTRL, 32'h41);
        wait_out(0, 1'b0);
        wr(A_CTRL, 32'h0);
        rng(A_COUNT, 0, 2);
    endtask

    task t_cmp1;
        wr(A_CTRL, 32'h0);
        wr(A_COUNT, 32'h0);
        wr(A_CC0, 32'h8);
        wr(A_CTRL, 32'h440);
        wr(A_PORT, 32'h1);
        rdc(A_PORT, 32'h10);
        wr(A_CTRL, 32'h441);
        wait_out(0, 1'b1);
        rdc(A_PORT, 32'h11);
    endtask

    task t_cap;
        wr(A_CTRL, 32'h0);
        wr(A_STAT, 32'h3ff);
        wr(A_COUNT, 32'habc);
        wr(A_CTRL, 32'h10000);
        pulse(4);
        rdc(A_CC0 + 8'h08, 32'habc);
        apb(1'b0, A_STAT, 32'h0);
        chk(32'(rd[ST_CAP + 2]), 32'h1);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = 6'h3f;
        err_count = 0;
        num_checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_rate(1'b0, 120 / MC_CYCLES);
        t_rate(1'b1, 120 / MC_CYCLES / 2);
        t_gated;
        t_event;
        t_reload;
        t_trig;
        t_cmp0;
        t_cmp1;
        t_cap;
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* File: tcc_cmp_chan.sv */
`timescale 1ns/1ns
`default_nettype none
module tcc_cmp_chan
    import tcc_pkg::*;
(
    input  wire logic pclk,    // clock
    input  wire logic presetn, // async reset, low
    input  wire logic en,      // compare enabled
    input  wire logic mode1,   // compare mode 1
    input  wire logic match,   // compare match pulse
    input  wire logic ovf,     // timer overflow pulse
    input  wire logic wr,      // software port write
    input  wire logic wdata,   // software port value
    output logic      pin,     // pin latch
    output logic      shadow   // shadow latch
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow <= 1'b0;
        end else if (wr && (!en || mode1)) begin
            shadow <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= 1'b0;
        end else if (en && !mode1) begin
            if (match) begin
                pin <= 1'b1;
            end else if (ovf) begin
                pin <= 1'b0;
            end
        end else if (en && mode1) begin
            if (match) begin
                pin <= shadow;
            end
        end else if (wr) begin
            pin <= wdata;
        end
    end

endmodule
`default_nettype wire

/* File: tcc_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model
    import tcc_pkg::*;
#(
    parameter int HOLD = 2 * MC_CYCLES
) (
    input  wire logic           pclk,                 // clock
    input  wire logic [5:0]     want,                 // levels asked for by the bench
    output logic                gate_count_input,     // gate / event pin
    output logic                reload_trigger_input, // trigger pin
    output logic      [NCH-1:0] capture_input         // capture pins
);
    // idle high; a pin takes a new level only once the old one stood HOLD cycles
    logic [5:0] lines = 6'h3f;
    int         age [6] = '{default: HOLD};
    assign gate_count_input     = lines[0];
    assign reload_trigger_input = lines[1];
    assign capture_input        = lines[5:2];

    always @(posedge pclk) begin
        for (int i = 0; i < 6; i++) begin
            if (want[i] !== lines[i] && age[i] >= HOLD) begin
                lines[i] <= want[i];
                age[i]   <= 0;
            end else if (age[i] < HOLD) begin
                age[i] <= age[i] + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tcc_pin_sample.sv */
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_sample
    import tcc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         pclk,    // clock
    input  wire logic         presetn, // async reset, low
    input  wire logic         mc_tick, // machine cycle strobe
    input  wire logic [W-1:0] pin,     // raw pins
    output logic      [W-1:0] level,   // sampled level
    output logic      [W-1:0] fall     // one-cycle falling edge
);

    logic [W-1:0] sync1;
    logic [W-1:0] sync2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
        end
    end

    // sampled once per machine cycle, an edge needs two samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
            fall  <= '0;
        end else begin
            fall <= '0;
            if (mc_tick) begin
                level <= sync2;
                fall  <= level & ~sync2;
            end
        end
    end

endmodule
`default_nettype wire

/* File: tcc_pkg.sv */
package tcc_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int PCLK_NS      = 50;
    localparam int MC_NS        = 300;
    localparam int MC_CYCLES    = (MC_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int RES_NS       = 600;
    localparam int MC_W         = 3;
    localparam int CNT_W        = 16;
    localparam int NCH          = 4;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_COUNT  = 8'h04;
    localparam logic [7:0] A_RELOAD = 8'h08;
    localparam logic [7:0] A_CC0    = 8'h0c;
    localparam logic [7:0] A_PORT   = 8'h1c;
    localparam logic [7:0] A_STAT   = 8'h20;
    localparam logic [7:0] A_MASK   = 8'h24;

    // ************************************************************
    // status bit positions
    // ************************************************************
    localparam int ST_OVF = 0;
    localparam int ST_EXT = 1;
    localparam int ST_CMP = 2;
    localparam int ST_CAP = 6;
    localparam int ST_W   = 10;

    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_MAX = 16'hffff;

    typedef enum logic [1:0] {
        TCC_STOP  = 2'b00,
        TCC_TIMER = 2'b01,
        TCC_GATED = 2'b11,
        TCC_EVENT = 2'b10
    } tcc_mode_t;

    typedef struct packed {
        logic [NCH-1:0] cap_en;
        logic [NCH-1:0] cmp_mode1;
        logic [NCH-1:0] cmp_en;
        logic           ext_reload_en;
        logic           reload_mode1;
        logic           reload_en;
        logic           div12;
        tcc_mode_t      mode;
    } tcc_ctrl_t;

    localparam int CTRL_W = $bits(tcc_ctrl_t);
    localparam logic [CTRL_W-1:0] CTRL_RST = 18'h00000;

endpackage

/* File: tcc_timer.sv */
// How it works
// - 16-bit counter, rollover sets overflow flag
// - timer mode counts at osc/6 or osc/12
// - gated mode counts only while gate high
// - event mode counts sampled gate falling edges
// - reload mode 0 reloads on overflow
// - reload mode 1 reloads on trigger fall
// - trigger fall sets flag if enabled
// - compare registers matched against timer continuously
// - compare mode 0 match drives output high
// - compare mode 0 overflow drives output low
// - compare mode 0 ignores software port writes
// - compare mode 1 shadow copied at match
// - four compare outputs, 600 ns resolution
// - four capture inputs, 600 ns resolution
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic              pclk,                 // clock
    input  wire logic              presetn,              // async reset, low
    input  wire logic              psel,                 // apb select
    input  wire logic              penable,              // apb enable
    input  wire logic              pwrite,               // apb write
    input  wire logic [7:0]        paddr,                // apb byte address
    input  wire logic [31:0]       pwdata,               // apb write data
    output logic      [31:0]       prdata,               // apb read data
    output logic                   pready,               // apb ready
    output logic                   pslverr,              // apb error
    input  wire logic              gate_count_input,     // gate / event pin
    input  wire logic              reload_trigger_input, // reload trigger pin
    input  wire logic [NCH-1:0]    capture_input,        // capture pins
    output logic      [NCH-1:0]    compare_output,       // compare pins
    output logic                   irq                   // interrupt level
);

    // ************************************************************
    // registers and wires
    // ************************************************************
    tcc_ctrl_t              ctrl;
    logic [CNT_W-1:0]       count;
    logic [CNT_W-1:0]       reload;
    logic [CNT_W-1:0]       cc [NCH];
    logic [ST_W-1:0]        status;
    logic [ST_W-1:0]        mask;
    logic [MC_W-1:0]        mc_cnt;
    logic                   mc_tick;
    logic                   half;
    logic                   gate_level;
    logic                   gate_fall;
    logic                   trig_fall;
    logic [NCH-1:0]         cap_fall;
    logic [NCH-1:0]         eq_prev;
    logic [NCH-1:0]         match;
    logic [NCH-1:0]         pin_q;
    logic [NCH-1:0]         shadow_q;
    logic                   step;
    logic                   ovf;
    logic                   wr;
    logic                   rd;
    logic [ST_W-1:0]        next_set;
    logic [31:0]            next_rdata;
    logic                   next_err;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        hit = (a == base);
    endfunction

    function automatic logic is_cc(input logic [7:0] a);
        is_cc = (a >= A_CC0) && (a < A_PORT) && (a[1:0] == 2'b00);
    endfunction

    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && !pready;

    // ************************************************************
    // machine cycle divider and prescaler
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt  <= '0;
            mc_tick <= 1'b0;
        end else begin
            mc_tick <= (mc_cnt == MC_W'(MC_CYCLES - 1));
            if (mc_cnt == MC_W'(MC_CYCLES - 1)) begin
                mc_cnt <= '0;
            end else begin
                mc_cnt <= mc_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half <= 1'b0;
        end else if (mc_tick) begin
            half <= ~half;
        end
    end

    // ************************************************************
    // pin sampling
    // ************************************************************
    tcc_pin_sample #(.W(1)) u_gate (
        .pclk    (pclk),
        .presetn (presetn),
        .mc_tick (mc_tick),
        .pin     (gate_count_input),
        .level   (gate_level),
        .fall    (gate_fall)
    );

    tcc_pin_sample #(.W(1)) u_trig (
        .pclk    (pclk),
        .presetn (presetn),
        .mc_tick (mc_tick),
        .pin     (reload_trigger_input),
        .level   (),
        .fall    (trig_fall)
    );

    tcc_pin_sample #(.W(NCH)) u_cap (
        .pclk    (pclk),
        .presetn (presetn),
        .mc_tick (mc_tick),
        .pin     (capture_input),
        .level   (),
        .fall    (cap_fall)
    );

    // ************************************************************
    // count step selection
    // ************************************************************
    always_comb begin
        case (ctrl.mode)
            TCC_TIMER: step = mc_tick && (!ctrl.div12 || half);
            TCC_GATED: step = mc_tick && (!ctrl.div12 || half) && gate_level;
            TCC_EVENT: step = gate_fall;
            TCC_STOP:  step = 1'b0;
            default:   step = 1'b0;
        endcase
    end

    assign ovf = step && (count == COUNT_MAX);

    // ************************************************************
    // counter with reload
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= COUNT_RST;
        end else if (wr && hit(paddr, A_COUNT)) begin
            count <= pwdata[CNT_W-1:0];
        end else if (ctrl.reload_en && ctrl.reload_mode1 && trig_fall) begin
            count <= reload;
        end else if (ovf && ctrl.reload_en && !ctrl.reload_mode1) begin
            count <= reload;
        end else if (step) begin
            count <= count + 1'b1;
        end
    end

    // ************************************************************
    // compare channels
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eq_prev <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                eq_prev[i] <= (count == cc[i]);
            end
        end
    end

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            // a match is the first cycle of equality
            assign match[g] = ctrl.cmp_en[g] && !ctrl.cap_en[g]
                              && (count == cc[g]) && !eq_prev[g];

            tcc_cmp_chan u_chan (
                .pclk    (pclk),
                .presetn (presetn),
                .en      (ctrl.cmp_en[g] && !ctrl.cap_en[g]),
                .mode1   (ctrl.cmp_mode1[g]),
                .match   (match[g]),
                .ovf     (ovf),
                .wr      (wr && hit(paddr, A_PORT)),
                .wdata   (pwdata[g]),
                .pin     (pin_q[g]),
                .shadow  (shadow_q[g])
            );
        end
    endgenerate

    assign compare_output = pin_q;

    // ************************************************************
    // compare / capture registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                cc[i] <= COUNT_RST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ctrl.cap_en[i] && cap_fall[i]) begin
                    cc[i] <= count;
                end else if (wr && hit(paddr, A_CC0 + 8'(4 * i))) begin
                    cc[i] <= pwdata[CNT_W-1:0];
                end
            end
        end
    end

    // ************************************************************
    // control, reload, mask
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= tcc_ctrl_t'(CTRL_RST);
            reload <= COUNT_RST;
            mask   <= '0;
        end else if (wr) begin
            if (hit(paddr, A_CTRL)) begin
                ctrl <= tcc_ctrl_t'(pwdata[CTRL_W-1:0]);
            end
            if (hit(paddr, A_RELOAD)) begin
                reload <= pwdata[CNT_W-1:0];
            end
            if (hit(paddr, A_MASK)) begin
                mask <= pwdata[ST_W-1:0];
            end
        end
    end

    // ************************************************************
    // status and interrupt
    // ************************************************************
    always_comb begin
        next_set         = '0;
        next_set[ST_OVF] = ovf;
        next_set[ST_EXT] = trig_fall && ctrl.ext_reload_en;
        next_set[ST_CMP +: NCH] = match;
        next_set[ST_CAP +: NCH] = cap_fall & ctrl.cap_en;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else if (wr && hit(paddr, A_STAT)) begin
            status <= (status & ~pwdata[ST_W-1:0]) | next_set;
        end else begin
            status <= status | next_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // ************************************************************
    // apb read path, one wait state
    // ************************************************************
    always_comb begin
        next_rdata = '0;
        next_err   = 1'b0;
        if (hit(paddr, A_CTRL)) begin
            next_rdata[CTRL_W-1:0] = ctrl;
        end else if (hit(paddr, A_COUNT)) begin
            next_rdata[CNT_W-1:0] = count;
        end else if (hit(paddr, A_RELOAD)) begin
            next_rdata[CNT_W-1:0] = reload;
        end else if (is_cc(paddr)) begin
            next_rdata[CNT_W-1:0] = cc[paddr[3:2] - 2'b11];
        end else if (hit(paddr, A_PORT)) begin
            next_rdata[NCH-1:0]     = pin_q;
            next_rdata[2*NCH-1:NCH] = shadow_q;
        end else if (hit(paddr, A_STAT)) begin
            next_rdata[ST_W-1:0] = status;
        end else if (hit(paddr, A_MASK)) begin
            next_rdata[ST_W-1:0] = mask;
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= rd;
            pslverr <= rd && next_err;
            if (rd && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

endmodule
`default_nettype wire

/* File: tcc_timer_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_properties
    import tcc_pkg::*;
(
    input wire logic           pclk,                 // clock
    input wire logic           presetn,              // reset, low
    input wire logic           psel,                 // apb select
    input wire logic           penable,              // apb enable
    input wire logic           pwrite,               // apb write
    input wire logic [7:0]     paddr,                // apb address
    input wire logic [31:0]    pwdata,               // apb write data
    input wire logic [31:0]    prdata,               // apb read data
    input wire logic           pready,               // apb ready
    input wire logic           pslverr,              // apb error
    input wire logic           gate_count_input,     // gate pin
    input wire logic           reload_trigger_input, // trigger pin
    input wire logic [NCH-1:0] capture_input,        // capture pins
    input wire logic [NCH-1:0] compare_output,       // compare pins
    input wire logic           irq                   // interrupt
);
    // ************************************************************
    // bus and interrupt relations
    // ************************************************************
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence access_s;
        psel && penable && !pready;
    endsequence
    sequence rd_done_s;
        pready && !pwrite;
    endsequence

    ready_wait_a: assert property (access_s |=> pready)
        else $error("ready missing after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_unmapped_a: assert property (pready && paddr > A_MASK |-> pslverr)
        else $error("unmapped access not refused");
    ok_mapped_a: assert property (pready && paddr <= A_MASK && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    rdata_hold_a: assert property (!$stable(prdata) |-> rd_done_s)
        else $error("read data moved outside a read");
    count_width_a: assert property (rd_done_s ##0 paddr == A_COUNT |-> prdata[31:16] == 16'h0000)
        else $error("count wider than 16 bits");
    port_width_a: assert property (rd_done_s ##0 paddr == A_PORT |-> prdata[31:8] == 24'h000000)
        else $error("port read upper bits set");
    irq_clear_a: assert property ($fell(irq) |-> $past(wr_done, 2))
        else $error("interrupt dropped without a write");
endmodule

bind tcc_timer tcc_timer_properties i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_count_input(gate_count_input), .reload_trigger_input(reload_trigger_input),
    .capture_input(capture_input), .compare_output(compare_output), .irq(irq)
);
`default_nettype wire
